/* File: common/esf_pkg.sv */
// Shared constants, register map and types for the engine start, fuel and excitation sequencer
package esf_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          TMR_W        = 16;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_FUNC     = 8'h04;
	localparam logic [7:0]  REG_FUEL_DLY = 8'h08;
	localparam logic [7:0]  REG_BELT     = 8'h0c;
	localparam logic [7:0]  REG_OUT_STAT = 8'h10;
	localparam logic [7:0]  REG_IN_STAT  = 8'h14;
	localparam logic [7:0]  REG_GPO      = 8'h18;

	// ==========================================================
	// Field positions
	localparam int CTRL_START    = 0;
	localparam int CTRL_STOP     = 1;
	localparam int CTRL_ENERGIZE = 2;
	localparam int CTRL_ACK_A    = 3;
	localparam int CTRL_ACK_B    = 4;
	localparam int CTRL_DIGIN    = 5;
	localparam int CTRL_ALM_CLR  = 8;
	localparam int FUNC_START_LO = 0;
	localparam int FUNC_FUEL_LO  = 2;
	localparam int FUNC_STOP_SEL = 4;
	localparam int BELT_CLS_LO   = 16;
	localparam int OST_STARTER   = 0;
	localparam int OST_FUEL      = 1;
	localparam int OST_AUX       = 2;
	localparam int OST_EXCITE    = 3;
	localparam int IST_DIGIN     = 0;
	localparam int IST_RUNNING   = 1;
	localparam int IST_ALARM     = 2;
	localparam int IST_LOCKED    = 3;
	localparam int IST_STATE_LO  = 8;
	localparam int GPO_START     = 0;
	localparam int GPO_FUEL      = 1;
	localparam int GPO_AUX       = 2;

	// ==========================================================
	// Reset values
	localparam logic [5:0]       CTRL_RST     = 6'h00;
	localparam logic [TMR_W-1:0] FUEL_DLY_RST = 16'h0000;
	localparam logic [TMR_W-1:0] BELT_TO_RST  = 16'h0000;

	// ==========================================================
	// Timing, one tick per millisecond
	localparam int CLK_HZ             = 100_000_000;
	localparam int TICK_MS            = 1;
	localparam int TICK_DIV_DEF       = CLK_HZ / 1000 * TICK_MS;
	localparam int FUEL_LEAD_MS       = 200;
	localparam int STARTER_REL_MIN_MS = 200;
	localparam int STARTER_REL_MAX_MS = 300;
	localparam int EXC_HOLD_S         = 30;
	localparam int EXC_PHASE_S        = 5;
	localparam int EXC_AFTER_S        = 5;
	localparam logic [TMR_W-1:0] FUEL_LEAD_TK   = TMR_W'((FUEL_LEAD_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [TMR_W-1:0] STARTER_REL_TK = TMR_W'((STARTER_REL_MIN_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [TMR_W-1:0] EXC_HOLD_TK    = TMR_W'(EXC_HOLD_S * 1000 / TICK_MS);
	localparam logic [TMR_W-1:0] EXC_PHASE_TK   = TMR_W'(EXC_PHASE_S * 1000 / TICK_MS);
	localparam logic [TMR_W-1:0] EXC_AFTER_TK   = TMR_W'(EXC_AFTER_S * 1000 / TICK_MS);

	// Digital-input thresholds on the sense voltage, millivolts
	localparam logic [15:0] DIGIN_ON_MV  = 16'd4000;
	localparam logic [15:0] DIGIN_OFF_MV = 16'd3500;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ESF_FN_ENGINE = 2'h0,
		ESF_FN_GPO    = 2'h1,
		ESF_FN_OFF    = 2'h2,
		ESF_FN_ON     = 2'h3
	} esf_fn_e;

	typedef enum logic {
		ESF_STOP_AUX  = 1'b0,
		ESF_STOP_FUEL = 1'b1
	} esf_stop_e;

	typedef enum logic [1:0] {
		ESF_CLS_WARN  = 2'h0,
		ESF_CLS_DEACT = 2'h1,
		ESF_CLS_LOCK  = 2'h2,
		ESF_CLS_RSVD  = 2'h3
	} esf_cls_e;

	typedef enum logic [5:0] {
		ESF_ST_IDLE    = 6'h01,
		ESF_ST_PRIME   = 6'h02,
		ESF_ST_CRANK   = 6'h04,
		ESF_ST_RUN     = 6'h08,
		ESF_ST_STOP    = 6'h10,
		ESF_ST_RELEASE = 6'h20
	} esf_state_e;

	typedef struct packed {
		logic starter_output;
		logic fuel_valve_output;
		logic aux_output;
		logic excite_out;
		logic excite_oe;
	} esf_pins_s;

	typedef struct packed {
		logic     broken_belt_alarm;
		esf_cls_e belt_alarm_class;
		logic     engine_locked;
	} esf_alarm_s;

endpackage : esf_pkg

/* File: core/esf_tick.sv */
// Millisecond tick prescaler for the sequence timers
`timescale 1ns/10ps
`default_nettype none

module esf_tick #(
	parameter int DIV = esf_pkg::TICK_DIV_DEF
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);
	import esf_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} esf_tick_s;

	esf_tick_s s;
	esf_tick_s next_s;

	always_comb begin
		next_s      = s;
		next_s.tick = 1'b0;
		if (s.cnt == 32'(DIV - 1)) begin
			next_s.cnt  = 32'h0000_0000;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule : esf_tick

`default_nettype wire

/* File: core/esf_ctrl.sv */
// Engine start, fuel valve and alternator excitation sequencer with APB registers
// Functional notes
// - Starter on for a start request, released 200-300 ms after running detected
// - Deenergize mode: fuel valve on at least 200 ms before starter
// - Deenergize mode: fuel held while running, engine stopped by dropping fuel
// - Engine stopped by other means: fuel release postponed by programmable delay
// - Status register shows starter and fuel outputs, 1 active, 0 inactive
// - Energize mode: engine runs until explicit stop output, auxiliary by default
// - Starter pin function selectable for use without engine control
// - Fuel pin function selectable for use without engine control
// - Excitation asserted together with the engine start command
// - Before acknowledgement excitation held 30 s, then 5 s on, 5 s off
// - After acknowledgement excitation kept 5 s more, then released
// - Sense voltage low after start or while running raises alarm after timeout
// - Alarm class warning, deactivation or lock; zero timeout disables alarm
// - Sense voltage acknowledges start only when enable settings allow it
// - Digital input mode reports pin input state, 1 active, 0 inactive
`timescale 1ns/10ps
`default_nettype none

module esf_ctrl #(
	parameter int TICK_DIV = esf_pkg::TICK_DIV_DEF
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic [esf_pkg::ADDR_W-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [esf_pkg::DATA_W-1:0] pwdata,
	output logic                           pready,
	output logic      [esf_pkg::DATA_W-1:0] prdata,
	output logic                           pslverr,
	input  wire logic                      engine_running_pin,
	input  wire logic [15:0]               alternator_sense_voltage,
	output esf_pkg::esf_pins_s             pins,
	output esf_pkg::esf_alarm_s            alarm
);
	import esf_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		esf_state_e       st;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] exc_tmr;
		logic [TMR_W-1:0] ph_tmr;
		logic             exc_ph;
		logic [TMR_W-1:0] ack_tmr;
		logic [TMR_W-1:0] belt_tmr;
		logic             alarm;
		logic [5:0]       ctrl;
		esf_fn_e          fn_start;
		esf_fn_e          fn_fuel;
		esf_stop_e        stop_sel;
		logic [TMR_W-1:0] fuel_dly;
		logic [TMR_W-1:0] belt_to;
		esf_cls_e         belt_cls;
		logic [2:0]       gpo;
		logic             digin;
		logic             run_s1;
		logic             run_s2;
		esf_pins_s        pins;
		logic             ack;
		logic [DATA_W-1:0] rdata;
	} esf_ctrl_s;

	esf_ctrl_s s;
	esf_ctrl_s next_s;
	logic      tick;

	esf_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	// ==========================================================
	// Functions
	function automatic logic fn_mux(input esf_fn_e fn, input logic eng, input logic gp);
		logic r;
		r = 1'b0;
		unique case (fn)
			ESF_FN_ENGINE: r = eng;
			ESF_FN_GPO:    r = gp;
			ESF_FN_OFF:    r = 1'b0;
			ESF_FN_ON:     r = 1'b1;
		endcase
		return r;
	endfunction : fn_mux

	function automatic logic [TMR_W-1:0] inc_sat(input logic [TMR_W-1:0] v, input logic en);
		logic [TMR_W-1:0] r;
		r = v;
		if (en && (v != {TMR_W{1'b1}})) begin
			r = v + TMR_W'(1);
		end
		return r;
	endfunction : inc_sat

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		return (a == REG_CTRL) || (a == REG_FUNC) || (a == REG_FUEL_DLY) || (a == REG_BELT) ||
			(a == REG_OUT_STAT) || (a == REG_IN_STAT) || (a == REG_GPO);
	endfunction : reg_mapped

	// ==========================================================
	// Derived conditions
	logic energize;
	logic run_other;
	logic dplus_crank;
	logic dplus_run;
	logic alarm_stops;
	logic access;
	logic wr_fire;
	logic eng_fuel;
	logic eng_starter;
	logic stop_cmd;
	logic alm_clr;

	always_comb begin
		energize    = s.ctrl[CTRL_ENERGIZE];
		run_other   = s.run_s2;
		dplus_crank = s.digin && s.ctrl[CTRL_ACK_A];
		dplus_run   = s.digin && s.ctrl[CTRL_ACK_B];
		alarm_stops = s.alarm && (s.belt_cls != ESF_CLS_WARN);
		access      = psel && penable;
		wr_fire     = access && s.ack && pwrite;
		alm_clr     = wr_fire && (paddr == REG_CTRL) && pwdata[CTRL_ALM_CLR];
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s        = s;
		next_s.run_s1 = engine_running_pin;
		next_s.run_s2 = s.run_s1;

		// Hysteretic level on the sense voltage
		if (alternator_sense_voltage > DIGIN_ON_MV) begin
			next_s.digin = 1'b1;
		end else if (alternator_sense_voltage < DIGIN_OFF_MV) begin
			next_s.digin = 1'b0;
		end

		// Sequencer
		unique case (s.st)
			ESF_ST_IDLE: begin
				next_s.tmr     = '0;
				next_s.ack_tmr = '0;
				if (s.ctrl[CTRL_START] && !s.ctrl[CTRL_STOP] && !alarm_stops) begin
					next_s.st = ESF_ST_PRIME;
				end
			end
			ESF_ST_PRIME: begin
				next_s.tmr = inc_sat(s.tmr, tick);
				if (s.ctrl[CTRL_STOP] || !s.ctrl[CTRL_START]) begin
					next_s.st = ESF_ST_IDLE;
				end else if (energize || (s.tmr >= FUEL_LEAD_TK)) begin
					next_s.st      = ESF_ST_CRANK;
					next_s.exc_tmr = '0;
					next_s.ph_tmr  = '0;
					next_s.exc_ph  = 1'b1;
				end
			end
			ESF_ST_CRANK: begin
				if (s.exc_tmr < EXC_HOLD_TK) begin
					next_s.exc_tmr = inc_sat(s.exc_tmr, tick);
				end else if (tick) begin
					if (s.ph_tmr >= EXC_PHASE_TK - TMR_W'(1)) begin
						next_s.ph_tmr = '0;
						next_s.exc_ph = !s.exc_ph;
					end else begin
						next_s.ph_tmr = s.ph_tmr + TMR_W'(1);
					end
				end
				if (s.ctrl[CTRL_STOP] || !s.ctrl[CTRL_START]) begin
					next_s.st  = ESF_ST_STOP;
					next_s.tmr = '0;
				end else if (run_other || dplus_crank) begin
					next_s.st      = ESF_ST_RUN;
					next_s.tmr     = '0;
					next_s.ack_tmr = '0;
				end
			end
			ESF_ST_RUN: begin
				next_s.tmr     = inc_sat(s.tmr, tick);
				next_s.ack_tmr = inc_sat(s.ack_tmr, tick);
				if (s.ctrl[CTRL_STOP] || alarm_stops) begin
					next_s.st  = ESF_ST_STOP;
					next_s.tmr = '0;
				end else if (!energize && !run_other && !dplus_run) begin
					next_s.st  = ESF_ST_RELEASE;
					next_s.tmr = '0;
				end
			end
			ESF_ST_STOP: begin
				if (!run_other && !dplus_run) begin
					next_s.st = ESF_ST_IDLE;
				end
			end
			ESF_ST_RELEASE: begin
				next_s.tmr = inc_sat(s.tmr, tick);
				if (s.tmr >= s.fuel_dly) begin
					next_s.st = ESF_ST_IDLE;
				end
			end
			default: begin
				next_s.st = ESF_ST_IDLE;
			end
		endcase

		// Belt watchdog, counts while running with the sense level low
		if ((s.st == ESF_ST_RUN) && !s.digin) begin
			next_s.belt_tmr = inc_sat(s.belt_tmr, tick);
		end else begin
			next_s.belt_tmr = '0;
		end
		if (alm_clr) begin
			next_s.alarm = 1'b0;
		end
		if ((s.belt_to != '0) && (s.belt_tmr >= s.belt_to)) begin
			next_s.alarm = 1'b1;
		end

		// Pin drive
		eng_starter = (s.st == ESF_ST_CRANK) || ((s.st == ESF_ST_RUN) && (s.tmr < STARTER_REL_TK));
		eng_fuel    = !energize && ((s.st == ESF_ST_PRIME) || (s.st == ESF_ST_CRANK) ||
			(s.st == ESF_ST_RUN) || (s.st == ESF_ST_RELEASE));
		stop_cmd    = energize && (s.st == ESF_ST_STOP);
		next_s.pins.starter_output = fn_mux(s.fn_start, eng_starter, s.gpo[GPO_START]);
		if (stop_cmd && (s.stop_sel == ESF_STOP_FUEL)) begin
			next_s.pins.fuel_valve_output = 1'b1;
		end else begin
			next_s.pins.fuel_valve_output = fn_mux(s.fn_fuel, eng_fuel, s.gpo[GPO_FUEL]);
		end
		next_s.pins.aux_output = (s.stop_sel == ESF_STOP_AUX) ? stop_cmd : s.gpo[GPO_AUX];
		next_s.pins.excite_oe  = !s.ctrl[CTRL_DIGIN];
		// Same one-cycle lag as the starter, so both commands rise on the same edge
		next_s.pins.excite_out = !s.ctrl[CTRL_DIGIN] &&
			(((s.st == ESF_ST_CRANK) && ((s.exc_tmr < EXC_HOLD_TK) || s.exc_ph)) ||
			((s.st == ESF_ST_RUN) && (s.ack_tmr < EXC_AFTER_TK)));

		// APB slave: one wait state, read data latched on the first access cycle
		next_s.ack = access && !s.ack;
		if (access && !s.ack) begin
			next_s.rdata = '0;
			unique case (paddr)
				REG_CTRL:     next_s.rdata[5:0] = s.ctrl;
				REG_FUNC:     next_s.rdata[FUNC_STOP_SEL:0] = {s.stop_sel, s.fn_fuel, s.fn_start};
				REG_FUEL_DLY: next_s.rdata[TMR_W-1:0] = s.fuel_dly;
				REG_BELT:     next_s.rdata[BELT_CLS_LO+1:0] = {s.belt_cls, s.belt_to};
				REG_OUT_STAT: begin
					next_s.rdata[OST_STARTER] = s.pins.starter_output;
					next_s.rdata[OST_FUEL]    = s.pins.fuel_valve_output;
					next_s.rdata[OST_AUX]     = s.pins.aux_output;
					next_s.rdata[OST_EXCITE]  = s.pins.excite_out;
				end
				REG_IN_STAT: begin
					next_s.rdata[IST_DIGIN]   = s.ctrl[CTRL_DIGIN] && s.digin;
					next_s.rdata[IST_RUNNING] = (s.st == ESF_ST_RUN);
					next_s.rdata[IST_ALARM]   = s.alarm;
					next_s.rdata[IST_LOCKED]  = s.alarm && (s.belt_cls == ESF_CLS_LOCK);
					next_s.rdata[IST_STATE_LO+5:IST_STATE_LO] = s.st;
				end
				REG_GPO:      next_s.rdata[2:0] = s.gpo;
				default:      next_s.rdata = '0;
			endcase
		end
		if (wr_fire) begin
			unique case (paddr)
				REG_CTRL:     next_s.ctrl = pwdata[5:0];
				REG_FUNC: begin
					next_s.fn_start = esf_fn_e'(pwdata[FUNC_START_LO+1:FUNC_START_LO]);
					next_s.fn_fuel  = esf_fn_e'(pwdata[FUNC_FUEL_LO+1:FUNC_FUEL_LO]);
					next_s.stop_sel = esf_stop_e'(pwdata[FUNC_STOP_SEL]);
				end
				REG_FUEL_DLY: next_s.fuel_dly = pwdata[TMR_W-1:0];
				REG_BELT: begin
					next_s.belt_to  = pwdata[TMR_W-1:0];
					next_s.belt_cls = esf_cls_e'(pwdata[BELT_CLS_LO+1:BELT_CLS_LO]);
				end
				REG_GPO:      next_s.gpo = pwdata[2:0];
				default:      next_s.gpo = s.gpo;
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			s          <= '0;
			s.st       <= ESF_ST_IDLE;
			s.ctrl     <= CTRL_RST;
			s.fn_start <= ESF_FN_ENGINE;
			s.fn_fuel  <= ESF_FN_ENGINE;
			s.stop_sel <= ESF_STOP_AUX;
			s.fuel_dly <= FUEL_DLY_RST;
			s.belt_to  <= BELT_TO_RST;
			s.belt_cls <= ESF_CLS_WARN;
			s.exc_ph   <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign pready  = access && s.ack;
	assign pslverr = access && s.ack && !reg_mapped(paddr);
	assign prdata  = s.rdata;
	assign pins    = s.pins;
	assign alarm   = '{broken_belt_alarm: s.alarm, belt_alarm_class: s.belt_cls,
		engine_locked: s.alarm && (s.belt_cls == ESF_CLS_LOCK)};

endmodule : esf_ctrl

`default_nettype wire

/* File: test/esf_ctrl_assertions.sv */
// Port checker for the engine start, fuel and excitation sequencer
`timescale 1ns/10ps
`default_nettype none
module esf_ctrl_assertions #(
	parameter int TICK_DIV = esf_pkg::TICK_DIV_DEF
) (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire logic [esf_pkg::ADDR_W-1:0] paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [esf_pkg::DATA_W-1:0] pwdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       engine_running_pin,
	input wire esf_pkg::esf_pins_s         pins,
	input wire esf_pkg::esf_alarm_s        alarm
);
	import esf_pkg::*;
	localparam int HOLD = 190 * TICK_DIV;
	localparam int WIN  = 120 * TICK_DIV;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Alarm clear write
	wire logic clr = psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[CTRL_ALM_CLR];
	// ==========================================================
	// Properties
	property p_ready_cause; pready |-> psel && penable; endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready outside an access");
	property p_ready_lat; psel && $rose(penable) |=> pready; endproperty
	a_ready_lat: assert property (p_ready_lat) else $error("ready late");
	property p_ready_once; pready |=> !pready; endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready held");
	property p_err_map; pslverr |-> pready && (paddr > REG_GPO || paddr[1:0] != 2'h0); endproperty
	a_err_map: assert property (p_err_map) else $error("error on mapped offset");
	property p_alarm_hold; alarm.broken_belt_alarm && !clr |=> alarm.broken_belt_alarm; endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
	property p_start_rel;
		$rose(engine_running_pin) && pins.starter_output |->
			(pins.starter_output throughout ##HOLD 1'b1) ##[1:WIN] !pins.starter_output;
	endproperty
	a_start_rel: assert property (p_start_rel) else $error("starter release time");
	property p_exc_start; $rose(pins.excite_out) |-> pins.starter_output; endproperty
	a_exc_start: assert property (p_exc_start) else $error("excite without start");
	property p_lock; $rose(alarm.engine_locked) |-> alarm.broken_belt_alarm && alarm.belt_alarm_class == ESF_CLS_LOCK;
	endproperty
	a_lock: assert property (p_lock) else $error("lock without lock alarm");
	c_start: cover property ($rose(pins.starter_output));
	c_alarm: cover property ($rose(alarm.broken_belt_alarm));
	c_err: cover property (pslverr);
endmodule : esf_ctrl_assertions
bind esf_ctrl esf_ctrl_assertions #(.TICK_DIV(TICK_DIV)) u_chk (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.engine_running_pin(engine_running_pin), .pins(pins), .alarm(alarm));
`default_nettype wire

/* File: test/esf_engine_model.sv */
// Behavioural engine, stop solenoid and charge alternator
`timescale 1ns/10ps
`default_nettype none
module esf_engine_model (
	input  wire logic               clk,
	input  wire logic [1:0]         mode,
	input  wire logic               energize,
	input  wire logic [15:0]        manual_mv,
	input  wire esf_pkg::esf_pins_s pins,
	output logic                    running,
	output logic [15:0]             sense_mv
);
	import esf_pkg::*;
	int crank = 0;
	initial running = 1'b0;
	// ==========================================================
	// Fires after 50 cranking cycles; mode 1 stalls, stop follows the stop method
	always @(posedge clk) begin
		crank <= pins.starter_output ? crank + 1 : 0;
		if (mode == 2'h1 || (energize ? pins.aux_output : !pins.fuel_valve_output)) begin
			running <= 1'b0;
		end else if (crank >= 50) begin
			running <= 1'b1;
		end
	end
	// Idle alternator terminal sits at ground; mode 2 is a broken belt
	assign sense_mv = (mode == 2'h3) ? manual_mv : (running && mode != 2'h2) ? 16'd12000 : 16'd0;
endmodule : esf_engine_model
`default_nettype wire

/* File: test/esf_ctrl_test.sv */
// Self-checking bench for the engine start, fuel and excitation sequencer
`timescale 1ns/10ps
`default_nettype none
module esf_ctrl_test;
	import esf_pkg::*;
	localparam int DIV = 1;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, run, err, engz = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [1:0]  mode = 2'h1;
	logic [15:0] mv = '0, sense;
	logic [5:0]  snap;
	esf_pins_s   pins;
	esf_alarm_s  alarm;
	int          bad_count = 0, checks_done = 0, n;
	wire logic [5:0] obs = {alarm.broken_belt_alarm, pins};
	esf_ctrl #(.TICK_DIV(DIV)) DUT (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.engine_running_pin(run), .alternator_sense_voltage(sense), .pins(pins), .alarm(alarm));
	esf_engine_model u_eng (.clk(clk), .mode(mode), .energize(engz), .manual_mv(mv), .pins(pins), .running(run),
		.sense_mv(sense));
	initial begin
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// Shared tasks
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic hang(input string nm);
		chk(nm, 32'h0, 32'h1);
		close_out();
	endtask : hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) hang("bus wait");
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic wt(input int i, input logic v, input int lim);
		n = 0;
		do begin
			@(negedge clk);
			n++;
			snap = obs;
		end while (obs[i] !== v && n <= lim);
		if (n > lim) hang("pin wait");
		@(posedge clk);
	endtask : wt
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		apb(1'b0, REG_CTRL, '0);
		chk("ctrl reset", rd, 32'h0);
		wr(REG_FUEL_DLY, 32'h64);
		apb(1'b0, REG_FUEL_DLY, '0);
		chk("fuel delay", rd, 32'h64);
		wr(8'h40, 32'h1);
		chk("unmapped error", 32'(err), 32'h1);
		apb(1'b0, 8'h40, '0);
		chk("unmapped read", {rd[30:0], err}, 32'h1);
	endtask : t_regs
	task automatic t_func;
		wr(REG_GPO, 32'h3);
		for (int c = 0; c < 4; c++) begin
			wr(REG_FUNC, 32'(c * 5));
			wt(4, c[0], 10);
			chk("starter function", 32'(snap[4]), 32'(c[0]));
			chk("fuel function", 32'(snap[3]), 32'(c[0]));
		end
		wr(REG_FUNC, '0);
		wr(REG_GPO, '0);
	endtask : t_func
	task automatic t_digin;
		logic [15:0] lv [4] = '{16'd3800, 16'd4100, 16'd3800, 16'd3400};
		mode <= 2'h3;
		wr(REG_CTRL, 32'h20);
		for (int i = 0; i < 4; i++) begin
			mv <= lv[i];
			repeat (4) @(posedge clk);
			apb(1'b0, REG_IN_STAT, '0);
			chk("digital input", 32'(rd[0]), 32'(i == 1 || i == 2));
		end
		wr(REG_CTRL, '0);
	endtask : t_digin
	task automatic t_start;
		mode <= 2'h0;
		wr(REG_BELT, '0);
		wr(REG_CTRL, 32'h1);
		wt(3, 1'b1, 20);
		wt(4, 1'b1, 400 * DIV);
		chk("fuel lead", 32'(n >= 200 * DIV), 32'h1);
		chk("excite with start", 32'(snap[1]), 32'h1);
		apb(1'b0, REG_OUT_STAT, '0);
		chk("output status", 32'(rd[1:0]), 32'h3);
		wt(4, 1'b0, 400 * DIV);
		chk("starter release", 32'(n >= 250 * DIV && n <= 354 * DIV), 32'h1);
		wt(1, 1'b0, 6000 * DIV);
		chk("excite after ack", 32'(n >= 4790 * DIV && n <= 4810 * DIV), 32'h1);
		wr(REG_CTRL, '0);
		mode <= 2'h1;
		wt(3, 1'b0, 400 * DIV);
		chk("fuel release delay", 32'(n >= 100 * DIV && n <= 110 * DIV), 32'h1);
	endtask : t_start
	task automatic t_excite;
		wr(REG_CTRL, 32'h1);
		wt(1, 1'b1, 400 * DIV);
		wt(1, 1'b0, 36000 * DIV);
		chk("excite hold", 32'(n >= 34995 * DIV && n <= 35005 * DIV), 32'h1);
		wt(1, 1'b1, 6000 * DIV);
		chk("excite off phase", 32'(n >= 4995 * DIV && n <= 5005 * DIV), 32'h1);
		wt(1, 1'b0, 6000 * DIV);
		chk("excite on phase", 32'(n >= 4995 * DIV && n <= 5005 * DIV), 32'h1);
		wr(REG_CTRL, '0);
		wt(3, 1'b0, 50);
	endtask : t_excite
	task automatic t_belt;
		wr(REG_BELT, 32'h0002_012c);
		mode <= 2'h2;
		wr(REG_CTRL, 32'h1);
		wt(5, 1'b1, 1000 * DIV);
		chk("belt alarm time", 32'(n >= 545 * DIV && n <= 570 * DIV), 32'h1);
		apb(1'b0, REG_IN_STAT, '0);
		chk("alarm and lock", 32'(rd[3:2]), 32'h3);
		wt(3, 1'b0, 50);
		chk("lock stops fuel", 32'(snap[3]), 32'h0);
		wr(REG_CTRL, 32'h100);
		wt(5, 1'b0, 10);
		wr(REG_BELT, '0);
	endtask : t_belt
	task automatic t_energize;
		mode <= 2'h0;
		engz <= 1'b1;
		wr(REG_CTRL, 32'h5);
		wt(4, 1'b1, 50);
		wt(4, 1'b0, 400 * DIV);
		apb(1'b0, REG_OUT_STAT, '0);
		chk("stop output idle", 32'(rd[2]), 32'h0);
		wr(REG_CTRL, 32'h6);
		wt(2, 1'b1, 50);
		chk("stop output", 32'(snap[2]), 32'h1);
		wr(REG_CTRL, '0);
		wt(2, 1'b0, 100);
	endtask : t_energize
	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		$display("registers done");
		t_func();
		$display("functions done");
		t_digin();
		$display("digital input done");
		t_start();
		$display("start done");
		t_excite();
		$display("excitation done");
		t_belt();
		$display("belt done");
		t_energize();
		$display("energize done");
		close_out();
	end
endmodule : esf_ctrl_test
`default_nettype wire
